/* File: design/dual_mod_counter.sv */
// dual_mod_counter: prescaler with swallow and program counters
// assumes step pulses are input edges sampled on the system clock
`timescale 1ns/100ps
module dual_mod_counter #(
  parameter int PRE_W = 6,
  parameter int BASE = 32,
  parameter int SW_W = 5,
  parameter int PG_W = 14
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  div_chain_if.div chain
);
  import synth_div_pkg::*;

  logic [PRE_W-1:0] pre_reg;
  logic [SW_W-1:0] swal_reg;
  logic [PG_W-1:0] prog_reg;

  // base+1 while swallowing, base afterwards
  wire swallowing = swal_reg != '0;
  wire [PRE_W-1:0] pre_last = swallowing ? PRE_W'(BASE) : PRE_W'(BASE - 1);
  wire pre_wrap = chain.step && (pre_reg == pre_last);
  // program count must not be below swallow count, else the cycle is short
  wire prog_last = prog_reg <= PG_W'(1);
  assign chain.terminal = pre_wrap && prog_last;

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pre_reg <= '0;
      swal_reg <= '0;
      prog_reg <= '0;
    end else if (chain.clear || chain.terminal) begin
      // both counters restart together
      pre_reg <= '0;
      swal_reg <= chain.swal;
      prog_reg <= chain.prog;
    end else if (pre_wrap) begin
      pre_reg <= '0;
      prog_reg <= prog_reg - PG_W'(1);
      swal_reg <= swal_reg - SW_W'(swallowing);
    end else if (chain.step) begin
      pre_reg <= pre_reg + PRE_W'(1);
    end
  end

  property p_reload;
    @(posedge sys_clk_in) disable iff (rst_in)
    chain.terminal |=> (prog_reg == $past(chain.prog)) && (swal_reg == $past(chain.swal));
  endproperty
  a_reload: assert property (p_reload) else $error("counters not reloaded");

  property p_pre_bound;
    @(posedge sys_clk_in) disable iff (rst_in)
    (swal_reg == '0) |-> (pre_reg <= PRE_W'(BASE - 1));
  endproperty
  a_pre_bound: assert property (p_pre_bound) else $error("prescaler overrun");

  c_terminal: cover property (@(posedge sys_clk_in) disable iff (rst_in) chain.terminal);
endmodule

/* File: design/synth_programmable_dividers.sv */
// synth_programmable_dividers: serial word intake, reference, auxiliary
// and main dividers with fractional accumulator
// assumes all pins are synchronous to sys_clk_in; divider inputs are
// sampled and counted on their rising edges
`timescale 1ns/100ps
module synth_programmable_dividers (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic ser_clk_in,
  input wire logic ser_data_in,
  input wire logic ser_strobe_in,
  input wire logic ref_input_in,
  input wire logic aux_osc_input_in,
  input wire logic main_osc_input_in,
  output wire logic ref_buf_enable_out,
  output wire logic aux_input_enable_out,
  output wire logic main_comp_enable_out,
  output wire logic main_ref_pulse_out,
  output wire logic aux_ref_pulse_out,
  output wire logic main_div_pulse_out,
  output wire logic aux_div_pulse_out,
  output wire logic speedup_active_out,
  output wire logic alt_scheme_select_out,
  output wire logic [synth_div_pkg::CN_W-1:0] pump_current_factor_out,
  output wire logic [synth_div_pkg::CK_W-1:0] integral_accel_factor_out,
  output wire logic [synth_div_pkg::CL_W-1:0] proportional_accel_factor_out,
  output wire logic main_pump_polarity_out,
  output wire logic aux_pump_polarity_out,
  output wire logic [3:0] txif_div_ratio_out,
  output wire logic tx_driver_low_current_out,
  output wire logic [synth_div_pkg::ACC_W-1:0] frac_accum_out
);
  import synth_div_pkg::*;

  // ---------------------------------------------------------------
  // input edge detection
  // ---------------------------------------------------------------
  logic ser_clk_d_reg;
  logic strobe_d_reg;
  logic ref_d_reg;
  logic aux_d_reg;
  logic main_d_reg;

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ser_clk_d_reg <= 1'b0;
      // strobe idles high, so a low reset value would fake a latch edge
      strobe_d_reg <= 1'b1;
      ref_d_reg <= 1'b0;
      aux_d_reg <= 1'b0;
      main_d_reg <= 1'b0;
    end else begin
      ser_clk_d_reg <= ser_clk_in;
      strobe_d_reg <= ser_strobe_in;
      ref_d_reg <= ref_input_in;
      aux_d_reg <= aux_osc_input_in;
      main_d_reg <= main_osc_input_in;
    end
  end

  // ---------------------------------------------------------------
  // serial word intake
  // ---------------------------------------------------------------
  logic [WORD_W-1:0] shift_reg;
  wire shift_en = ser_clk_in & ~ser_clk_d_reg & ~ser_strobe_in;
  wire strobe_rise = ser_strobe_in & ~strobe_d_reg;
  wire [3:0] word_addr = shift_reg[ADDR_LSB +: 4];
  wire [PAY_W-1:0] word_pay = shift_reg[PAY_W-1:0];
  wire is_a = shift_reg[A_FLAG_BIT];
  // unknown addresses, including the test word, are dropped
  wire take_a = strobe_rise & is_a;
  wire take_b = strobe_rise & ~is_a & (word_addr == ADDR_B);
  wire take_c = strobe_rise & ~is_a & (word_addr == ADDR_C);
  wire take_d = strobe_rise & ~is_a & (word_addr == ADDR_D);
  wire take_g = strobe_rise & ~is_a & (word_addr == ADDR_G);

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      shift_reg <= '0;
    end else if (shift_en) begin
      shift_reg <= {ser_data_in, shift_reg[WORD_W-1:1]};
    end
  end

  logic [A_PAY_W-1:0] a_pend_reg;
  logic [A_PAY_W-1:0] a_work_reg;
  logic a_pend_valid_reg;
  logic [PAY_W-1:0] b_temp_reg;
  logic [PAY_W-1:0] b_work_reg;
  logic [PAY_W-1:0] c_reg;
  logic [PAY_W-1:0] d_reg;
  logic [PAY_W-1:0] g_reg;
  logic main_term;
  logic em;

  // a disabled divider has no terminal count, so a word loads at once
  wire main_load = a_pend_valid_reg & (main_term | ~em);

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      a_pend_reg <= '0;
      a_work_reg <= '0;
      a_pend_valid_reg <= 1'b0;
      b_temp_reg <= '0;
      b_work_reg <= '0;
      c_reg <= '0;
      d_reg <= '0;
      g_reg <= '0;
    end else begin
      if (take_a) begin
        a_pend_reg <= shift_reg[A_PAY_W-1:0];
      end
      // a word arriving with the load stays pending
      if (take_a) begin
        a_pend_valid_reg <= 1'b1;
      end else if (main_load) begin
        a_pend_valid_reg <= 1'b0;
      end
      // pump word rides along so type and ratio switch together
      if (main_load) begin
        a_work_reg <= a_pend_reg;
        b_work_reg <= b_temp_reg;
      end
      if (take_b) begin
        b_temp_reg <= word_pay;
      end
      if (take_c) begin
        c_reg <= word_pay;
      end
      if (take_d) begin
        d_reg <= word_pay;
      end
      if (take_g) begin
        g_reg <= word_pay;
      end
    end
  end

  // ---------------------------------------------------------------
  // enables
  // ---------------------------------------------------------------
  assign em = d_reg[EM_BIT];
  wire ea = d_reg[EA_BIT];
  wire alt_scheme_select = c_reg[ALT_BIT];
  wire ref_buf_en = em | ea;
  wire ref_edge = ref_input_in & ~ref_d_reg & ref_buf_en;
  wire aux_edge = aux_osc_input_in & ~aux_d_reg & ea;
  wire main_edge = main_osc_input_in & ~main_d_reg & em;

  // ---------------------------------------------------------------
  // main ratio, taken from the word that will be in force
  // ---------------------------------------------------------------
  wire [A_PAY_W-1:0] nxt_a = main_load ? a_pend_reg : a_work_reg;
  wire [PAY_W-1:0] nxt_b = main_load ? b_temp_reg : b_work_reg;
  wire triple = nxt_b[PR_HI_BIT];
  wire [N_W-1:0] nm1 = N_W'(nxt_a[NM1_LSB +: NM1_W]);
  // second count is 4 bits wide for triple-modulus types
  wire [N_W-1:0] nm2 = triple ? N_W'(nxt_a[NM2_LSB +: NM3_W]) :
                                N_W'(nxt_a[NM2_LSB +: NM2_W]);
  wire [N_W-1:0] nm3 = triple ? N_W'(nxt_a[NM3_LSB +: NM3_W]) : '0;
  wire [N_W-1:0] n_third = triple ? RATIO_R3 * (nm3 + NM3_OFS) : '0;
  wire [N_W-1:0] n_std = RATIO_R1 * (nm1 + NM1_OFS) + RATIO_R2 * nm2 + n_third;
  wire [N_W-1:0] n_alt = N_W'(nxt_a[NM_LSB +: NM_W]);
  wire [NF_W-1:0] nf = alt_scheme_select ? nxt_a[NF_ALT_LSB +: NF_W] :
                             NF_W'(nxt_a[NF_STD_LSB +: NF_STD_W]);
  wire [ACC_W-1:0] frac_modulus_std = nxt_b[FRAC_MODULUS_FLAG_BIT] ? FRAC_MODULUS_STD_HI : FRAC_MODULUS_STD_LO;
  wire [ACC_W-1:0] frac_modulus = alt_scheme_select ? c_reg[FRAC_MODULUS_LSB +: FRAC_MODULUS_W] : frac_modulus_std;

  // ---------------------------------------------------------------
  // fractional accumulator
  // ---------------------------------------------------------------
  logic [ACC_W-1:0] acc_reg;
  wire [ACC_W:0] acc_sum = {1'b0, acc_reg} + {2'b00, nf};
  // a zero modulus means integer operation
  wire ovf = (frac_modulus != '0) && (acc_sum >= {1'b0, frac_modulus});
  wire [ACC_W:0] acc_wrap = acc_sum - {1'b0, frac_modulus};
  wire [ACC_W-1:0] acc_next = (frac_modulus == '0) ? '0 :
                              ovf ? acc_wrap[ACC_W-1:0] : acc_sum[ACC_W-1:0];
  // overflow of this update stretches the coming cycle by one
  wire [N_W-1:0] n_sel = (alt_scheme_select ? n_alt : n_std) + N_W'(ovf);

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      acc_reg <= '0;
    end else if (!em) begin
      acc_reg <= '0;
    end else if (main_term) begin
      acc_reg <= acc_next;
    end
  end

  // ---------------------------------------------------------------
  // main and auxiliary chains
  // ---------------------------------------------------------------
  // any ratio N maps to 32*program + swallow, so both schemes share
  // one 32/33 chain
  div_chain_if #(.SW_W(MAIN_SW_W), .PG_W(MAIN_PG_W)) main_chain();
  assign main_chain.clear = ~em;
  assign main_chain.step = main_edge;
  assign main_chain.swal = n_sel[MAIN_SW_W-1:0];
  assign main_chain.prog = n_sel[N_W-1:MAIN_SW_W];
  assign main_term = main_chain.terminal;

  dual_mod_counter #(
    .PRE_W(MAIN_PRE_W),
    .BASE(MAIN_BASE),
    .SW_W(MAIN_SW_W),
    .PG_W(MAIN_PG_W)
  ) u_main_div (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .chain(main_chain.div)
  );

  // auxiliary ratio 8*program + swallow
  div_chain_if #(.SW_W(AUX_SW_W), .PG_W(AUX_PG_W)) aux_chain();
  assign aux_chain.clear = ~ea;
  assign aux_chain.step = aux_edge;
  assign aux_chain.swal = c_reg[NA_LSB +: AUX_SW_W];
  assign aux_chain.prog = c_reg[NA_LSB + AUX_SW_W +: AUX_PG_W];

  dual_mod_counter #(
    .PRE_W(AUX_PRE_W),
    .BASE(AUX_BASE),
    .SW_W(AUX_SW_W),
    .PG_W(AUX_PG_W)
  ) u_aux_div (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .chain(aux_chain.div)
  );

  // ---------------------------------------------------------------
  // reference divider and postscalers
  // ---------------------------------------------------------------
  logic [NR_W-1:0] ref_cnt_reg;
  logic [2:0] post_cnt_reg;
  wire [NR_W-1:0] nr = d_reg[NR_LSB +: NR_W];
  // ratios below four are outside the valid range and not guarded
  wire ref_tick = ref_edge && (ref_cnt_reg + 12'h001 >= nr);
  wire [2:0] mask_m = post_mask(d_reg[RSM_LSB +: SEL_W]);
  wire [2:0] mask_a = post_mask(d_reg[RSA_LSB +: SEL_W]);
  wire main_post_hit = ref_tick && ((post_cnt_reg & mask_m) == mask_m);
  wire aux_post_hit = ref_tick && ((post_cnt_reg & mask_a) == mask_a);

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ref_cnt_reg <= '0;
      post_cnt_reg <= '0;
    end else if (!ref_buf_en) begin
      ref_cnt_reg <= '0;
      post_cnt_reg <= '0;
    end else if (ref_edge) begin
      ref_cnt_reg <= ref_tick ? '0 : ref_cnt_reg + 12'h001;
      post_cnt_reg <= post_cnt_reg + 3'(ref_tick);
    end
  end

  // ---------------------------------------------------------------
  // speed-up timer and output pulses
  // ---------------------------------------------------------------
  logic [SPD_W-1:0] speed_cnt_reg;
  logic main_ref_pulse_reg;
  logic aux_ref_pulse_reg;
  logic main_div_pulse_reg;
  logic aux_div_pulse_reg;

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      speed_cnt_reg <= '0;
      main_ref_pulse_reg <= 1'b0;
      aux_ref_pulse_reg <= 1'b0;
      main_div_pulse_reg <= 1'b0;
      aux_div_pulse_reg <= 1'b0;
    end else begin
      if (main_load && alt_scheme_select) begin
        speed_cnt_reg <= b_temp_reg[SPD_LSB +: SPD_W];
      end else if (ref_tick && speed_cnt_reg != '0) begin
        speed_cnt_reg <= speed_cnt_reg - 4'h1;
      end
      main_ref_pulse_reg <= main_post_hit;
      aux_ref_pulse_reg <= aux_post_hit;
      main_div_pulse_reg <= main_term;
      aux_div_pulse_reg <= aux_chain.terminal;
    end
  end

  assign ref_buf_enable_out = ref_buf_en;
  assign aux_input_enable_out = ea;
  assign main_comp_enable_out = em;
  assign main_ref_pulse_out = main_ref_pulse_reg;
  assign aux_ref_pulse_out = aux_ref_pulse_reg;
  assign main_div_pulse_out = main_div_pulse_reg;
  assign aux_div_pulse_out = aux_div_pulse_reg;
  assign speedup_active_out = speed_cnt_reg != '0;
  assign alt_scheme_select_out = alt_scheme_select;
  assign pump_current_factor_out = b_work_reg[CN_LSB +: CN_W];
  assign integral_accel_factor_out = b_work_reg[CK_LSB +: CK_W];
  assign proportional_accel_factor_out = b_work_reg[CL_LSB +: CL_W];
  assign main_pump_polarity_out = alt_scheme_select & b_work_reg[MPOL_BIT];
  assign aux_pump_polarity_out = alt_scheme_select & b_work_reg[APOL_BIT];
  assign txif_div_ratio_out = TXIF_BASE + {2'b00, g_reg[TXN_LSB +: TXN_W]};
  assign tx_driver_low_current_out = ~g_reg[MODE_BIT];
  assign frac_accum_out = acc_reg;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (rst_in);

  property p_shift;
    shift_en |=> shift_reg[WORD_W-1] == $past(ser_data_in);
  endproperty
  a_shift: assert property (p_shift) else $error("serial bit lost");

  property p_hold;
    a_pend_valid_reg && !main_load |=> $stable(a_work_reg);
  endproperty
  a_hold: assert property (p_hold) else $error("main word loaded early");

  property p_load_cause;
    !$stable(a_work_reg) |-> $past(main_load);
  endproperty
  a_load_cause: assert property (p_load_cause) else $error("main word changed");

  property p_ref_buf;
    take_d |=> ref_buf_enable_out == ($past(shift_reg[EM_BIT]) | $past(shift_reg[EA_BIT]));
  endproperty
  a_ref_buf: assert property (p_ref_buf) else $error("reference buffer enable");

  property p_aux_en;
    take_d |=> aux_input_enable_out == $past(shift_reg[EA_BIT]);
  endproperty
  a_aux_en: assert property (p_aux_en) else $error("aux input enable");

  property p_main_en;
    take_d ##1 !main_comp_enable_out |-> !main_chain.step;
  endproperty
  a_main_en: assert property (p_main_en) else $error("main comparator active");

  property p_acc;
    main_term && frac_modulus != '0 && acc_reg < frac_modulus && nf < frac_modulus |=> acc_reg < $past(frac_modulus);
  endproperty
  a_acc: assert property (p_acc) else $error("accumulator out of range");

  property p_post;
    ref_tick && d_reg[RSM_LSB +: SEL_W] == '0 |=> main_ref_pulse_out;
  endproperty
  a_post: assert property (p_post) else $error("main reference pulse missing");

  property p_speed;
    main_load && alt_scheme_select && b_temp_reg[SPD_LSB +: SPD_W] != '0 |=> speedup_active_out;
  endproperty
  a_speed: assert property (p_speed) else $error("speed-up not started");

  property p_txif;
    take_g |=> txif_div_ratio_out == TXIF_BASE + {2'b00, $past(shift_reg[1:0])};
  endproperty
  a_txif: assert property (p_txif) else $error("offset divider ratio");

  c_main_term: cover property (main_term);
  c_overflow: cover property (main_term && ovf);
  c_aux_term: cover property (aux_chain.terminal);
  c_speedup: cover property (speedup_active_out ##1 !speedup_active_out);
endmodule

/* File: dv/host_osc_model.sv */
// host_osc_model: serial programming host and one free-running oscillator
// assumes the 200 MHz system clock; every pin changes 1 ns after its rise
`timescale 1ns/100ps
module host_osc_model (
  input wire logic sys_clk_in,
  output logic ser_clk_out,
  output logic ser_data_out,
  output logic ser_strobe_out,
  output logic osc_out
);
  logic [1:0] phase_reg = 2'h0;
  initial begin
    ser_clk_out = 1'h0;
    ser_data_out = 1'h0;
    ser_strobe_out = 1'h1;
  end
  // quarter rate keeps each edge well under the sampling limit
  always @(posedge sys_clk_in) phase_reg <= #1 phase_reg + 2'h1;
  assign osc_out = phase_reg[1];
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask
  // ----
  // word transfer
  // ----
  task automatic send_word(input logic [23:0] w);
    for (int i = 0; i < 24; i++) begin
      tick(1);
      ser_strobe_out = 1'h0;
      ser_data_out = w[i]; // lsb first
      ser_clk_out = 1'h0;
      tick(2);
      ser_clk_out = 1'h1; // shift edge while strobe low
      tick(1);
    end
    tick(1);
    ser_clk_out = 1'h0;
    ser_data_out = ~ser_data_out;
    tick(1);
    ser_strobe_out = 1'h1; // latch
    tick(2);
  endtask
endmodule

/* File: dv/synth_programmable_dividers_test.sv */
// synth_programmable_dividers_test: self-checking bench for the divider block
// assumes host_osc_model drives the serial pins and all three divider inputs
`timescale 1ns/100ps
module synth_programmable_dividers_test;
  import synth_div_pkg::*;
  logic sys_clk_in = 1'h0;
  logic rst_in = 1'h1;
  logic ser_clk_in, ser_data_in, ser_strobe_in, osc;
  wire ref_input_in, aux_osc_input_in, main_osc_input_in;
  logic ref_buf_enable_out, aux_input_enable_out, main_comp_enable_out, main_ref_pulse_out;
  logic aux_ref_pulse_out, main_div_pulse_out, aux_div_pulse_out, speedup_active_out;
  logic alt_scheme_select_out, main_pump_polarity_out, aux_pump_polarity_out;
  logic tx_driver_low_current_out;
  logic [CN_W-1:0] pump_current_factor_out;
  logic [CK_W-1:0] integral_accel_factor_out;
  logic [CL_W-1:0] proportional_accel_factor_out;
  logic [3:0] txif_div_ratio_out;
  logic [ACC_W-1:0] frac_accum_out;
  int mismatches = 0;
  int checks = 0;
  always #2.5 sys_clk_in = ~sys_clk_in;
  assign {ref_input_in, aux_osc_input_in, main_osc_input_in} = {3{osc}};
  host_osc_model host_osc_model_i (.sys_clk_in(sys_clk_in), .ser_clk_out(ser_clk_in),
    .ser_data_out(ser_data_in), .ser_strobe_out(ser_strobe_in), .osc_out(osc));
  synth_programmable_dividers synth_programmable_dividers_i (.*);
  task automatic wrap_up();
    if (mismatches == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  function automatic logic pk(input int s);
    case (s)
      0: return main_div_pulse_out;
      1: return aux_div_pulse_out;
      2: return main_ref_pulse_out;
      default: return aux_ref_pulse_out;
    endcase
  endfunction
  // skips the first, possibly partial, period and the full period after it before measuring
  task automatic span(input string nm, input int s, input int exp);
    int n;
    int t0;
    n = 0;
    t0 = 0;
    for (int k = 0; k < 3; k++) begin
      do begin
        tick(1);
        n++;
      end while (pk(s) !== 1'h1 && n < 20000);
      if (k == 1) t0 = n;
    end
    checks++;
    if (n - t0 != exp) begin
      mismatches++;
      $display("BAD %s expected %0d seen %0d", nm, exp, n - t0);
    end
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_general();
    logic [1:0] c;
    for (int i = 0; i < 4; i++) begin
      c = 2'(i);
      host_osc_model_i.send_word({4'h3, 17'h0_0000, c[0], c});
      tick(2);
      chk("txif", 8'(6 + i), 8'(txif_div_ratio_out));
      chk("low_cur", 8'(!c[0]), 8'(tx_driver_low_current_out));
    end
  endtask
  task automatic t_alt_main();
    host_osc_model_i.send_word({4'h1, 1'h0, 5'h00, 13'h0039, 1'h1}); // auxiliary program 7, swallow 1
    host_osc_model_i.send_word({4'h0, 4'h2, 4'h9, 2'h2, 8'ha5, 2'h1});
    host_osc_model_i.send_word({2'h2, 4'h0, 18'h0_03e1}); // program 31, swallow 1
    tick(2);
    chk("alt", 8'h01, 8'(alt_scheme_select_out));
    chk("cn", 8'ha5, pump_current_factor_out);
    chk("ck", 8'h09, 8'(integral_accel_factor_out));
    chk("cl", 8'h02, 8'(proportional_accel_factor_out));
    chk("pol", 8'h01, 8'({aux_pump_polarity_out, main_pump_polarity_out}));
    chk("speedup", 8'h01, 8'(speedup_active_out));
  endtask
  task automatic t_enables();
    logic [1:0] e;
    for (int i = 0; i < 4; i++) begin
      e = 2'(i);
      host_osc_model_i.send_word({4'h2, 2'h0, e, 16'h0000});
      tick(2);
      chk("ref_buf", 8'(|e), 8'(ref_buf_enable_out));
      chk("aux_en", 8'(e[1]), 8'(aux_input_enable_out));
      chk("main_en", 8'(e[0]), 8'(main_comp_enable_out));
    end
  endtask
  task automatic t_dividers();
    host_osc_model_i.send_word({4'h2, 2'h0, 2'h3, 2'h0, 2'h2, 12'h004});
    span("main_div", 0, 3972); // 32*(31-1)+33 input cycles
    span("aux_div", 1, 228); // 8*(7-1)+9
    span("main_ref", 2, 64);
    span("aux_ref", 3, 16);
    chk("speedup", 8'h00, 8'(speedup_active_out));
    chk("acc", 8'h00, 8'(frac_accum_out));
  endtask
  // triple-modulus standard word; sent while still alternate so the long
  // interim ratio cannot stall the chain, then the scheme bit is cleared
  task automatic t_standard();
    host_osc_model_i.send_word({4'h0, 4'h0, 4'h0, 2'h0, 8'h00, 2'h2});
    host_osc_model_i.send_word({1'h1, 3'h0, 4'h0, 4'h0, 12'h00e});
    host_osc_model_i.send_word({4'h1, 1'h0, 5'h00, 13'h0039, 1'h0});
    span("std_div", 0, 4384); // 64*(14+2)+72*(0+1) input cycles
    chk("std_pol", 8'h00, 8'({aux_pump_polarity_out, main_pump_polarity_out}));
    chk("std_acc", 8'h00, 8'(frac_accum_out));
  endtask
  initial begin
    tick(4);
    rst_in = 1'h0;
    tick(1);
    chk("txif", 8'h06, 8'(txif_div_ratio_out));
    chk("low_cur", 8'h01, 8'(tx_driver_low_current_out));
    t_general();
    t_alt_main();
    t_enables();
    t_dividers();
    t_standard();
    wrap_up();
  end
  initial begin
    #400000;
    mismatches++;
    wrap_up();
  end
endmodule

/* File: pkg/div_chain_if.sv */
// div_chain_if: control and terminal signals of one dual-modulus chain
// assumes both ends run on the system clock
`timescale 1ns/100ps
interface div_chain_if #(
  parameter int SW_W = 5,
  parameter int PG_W = 14
);
  logic clear;
  logic step;
  logic [SW_W-1:0] swal;
  logic [PG_W-1:0] prog;
  logic terminal;
  modport ctrl(output clear, step, swal, prog, input terminal);
  modport div(input clear, step, swal, prog, output terminal);
endinterface

/* File: pkg/synth_div_pkg.sv */
// synth_div_pkg: constants shared by the synthesizer divider block
// assumes one 200 MHz system clock and pin inputs synchronous to it
package synth_div_pkg;
  // serial word layout
  localparam int WORD_W = 24;
  localparam int PAY_W = 20;
  localparam int A_PAY_W = 23;
  localparam int A_FLAG_BIT = 23;
  localparam int ADDR_LSB = 20;
  localparam logic [3:0] ADDR_B = 4'h0;
  localparam logic [3:0] ADDR_C = 4'h1;
  localparam logic [3:0] ADDR_D = 4'h2;
  localparam logic [3:0] ADDR_G = 4'h3;
  // main word fields
  localparam int NM1_LSB = 0;
  localparam int NM1_W = 12;
  localparam int NM2_LSB = 12;
  localparam int NM2_W = 8;
  localparam int NM3_LSB = 16;
  localparam int NM3_W = 4;
  localparam int NF_STD_LSB = 20;
  localparam int NF_STD_W = 3;
  localparam int NM_LSB = 0;
  localparam int NM_W = 18;
  localparam int NF_ALT_LSB = 18;
  localparam int NF_W = 4;
  // pump word fields
  localparam int PR_HI_BIT = 1;
  localparam int MPOL_BIT = 0;
  localparam int APOL_BIT = 1;
  localparam int CN_LSB = 2;
  localparam int CN_W = 8;
  localparam int CL_LSB = 10;
  localparam int CL_W = 2;
  localparam int CK_LSB = 12;
  localparam int CK_W = 4;
  localparam int FRAC_MODULUS_FLAG_BIT = 16;
  localparam int SPD_LSB = 16;
  localparam int SPD_W = 4;
  // auxiliary / mode word fields
  localparam int ALT_BIT = 0;
  localparam int NA_LSB = 1;
  localparam int AUX_SW_W = 3;
  localparam int AUX_PG_W = 10;
  localparam int FRAC_MODULUS_LSB = 14;
  localparam int FRAC_MODULUS_W = 5;
  // reference word fields
  localparam int NR_LSB = 0;
  localparam int NR_W = 12;
  localparam int RSM_LSB = 12;
  localparam int RSA_LSB = 14;
  localparam int SEL_W = 2;
  localparam int EM_BIT = 16;
  localparam int EA_BIT = 17;
  // general word fields
  localparam int TXN_LSB = 0;
  localparam int TXN_W = 2;
  localparam int MODE_BIT = 2;
  // divider chains
  localparam int N_W = 19;
  localparam int ACC_W = 5;
  localparam int MAIN_SW_W = 5;
  localparam int MAIN_PG_W = 14;
  localparam int MAIN_PRE_W = 6;
  localparam int MAIN_BASE = 32;
  localparam int AUX_PRE_W = 4;
  localparam int AUX_BASE = 8;
  localparam logic [N_W-1:0] RATIO_R1 = 19'h0_0040;
  localparam logic [N_W-1:0] RATIO_R2 = 19'h0_0041;
  localparam logic [N_W-1:0] RATIO_R3 = 19'h0_0048;
  localparam logic [N_W-1:0] NM1_OFS = 19'h0_0002;
  localparam logic [N_W-1:0] NM3_OFS = 19'h0_0001;
  localparam logic [ACC_W-1:0] FRAC_MODULUS_STD_HI = 5'h08;
  localparam logic [ACC_W-1:0] FRAC_MODULUS_STD_LO = 5'h05;
  localparam logic [3:0] TXIF_BASE = 4'h6;

  // postscaler hit mask: 1, 2, 4 or 8 reference cycles per output
  function automatic logic [2:0] post_mask(input logic [SEL_W-1:0] sel);
    logic [2:0] m;
    m = 3'h0;
    unique case (sel)
      2'h0: m = 3'h0;
      2'h1: m = 3'h1;
      2'h2: m = 3'h3;
      2'h3: m = 3'h7;
    endcase
    return m;
  endfunction
endpackage
